// [src/fso_status_bank.v]
// Notes on behaviour
// - supply summary bit 7 clears by written zero only when no fault other than k-line over-temperature is still present
// - each sticky fault bit clears by written zero only after its fault ended
// - open load is detected while the output is commanded off, via comparator
// - every output has its own comparator and its own open load flag
// - pull-downs are on from power-up; open load detection needs them on
// - with its pull-down off, an output's open load bit reads zero
// - pull-downs turn off only in sleep or when commanded off serially
// - open load must persist through a filter of 100 to 450 us
// - each rising edge of chip select restarts the fault delay timer
// - open load comparator is enabled only after the delay timer expires
// - open load flag stays latched after the condition goes away
`include "fso_map.vh"
`default_nettype none

module fso_status_bank #(
   parameter [`FSO_CNT_W-1:0] FILT_CYC = `FSO_FILT_CYC
) (
   // clock and reset
   input  wire       sys_clk_i,
   input  wire       sys_rst_i,
   // register access port
   input  wire [3:0] reg_addr_i,
   input  wire       reg_wr_i,
   input  wire       reg_rd_i,
   input  wire [7:0] reg_wdata_i,
   output wire [7:0] reg_rdata_o,
   output wire       reg_rvalid_o,
   // serial frame select
   input  wire       chip_select_n_i,
   // predriver channels: heater, spark one, spark two
   input  wire [2:0] pd_out_on_i,
   input  wire [2:0] pd_ol_cmp_i,
   input  wire [2:0] pd_oc_det_i,
   // pull-down control
   input  wire       sleep_i,
   input  wire [2:0] pulldown_off_i,
   output wire [2:0] pulldown_en_o,
   // watchdog state
   input  wire [7:0] wd_state_i,
   // pickup conditioner and k-line
   input  wire [3:0] pickup_peak_i,
   input  wire       pickup_pos_clamp_i,
   input  wire       pickup_neg_clamp_i,
   input  wire       kline_ot_i,
   // supply and system
   input  wire       keysw_i,
   input  wire       power_hold_output_i,
   input  wire       batsw_i,
   input  wire       spi_error_i,
   input  wire       vprot_bat_i,
   input  wire       vprot_ot_i,
   input  wire       vprot_gnd_i,
   // output on indicators
   input  wire [7:0] out_on_ind_i
);

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   reg  [7:0]            rdata_r;
   reg  [7:0]            rdata_nxt;
   reg                   rvalid_r;
   reg  [2:0]            pd_en_r;
   reg                   cs_n_q_r;
   reg  [`FSO_CNT_W-1:0] dly_cnt_r;
   reg  [4:0]            misc_r;
   reg                   sup_sum_r;
   wire                  cs_rise;
   wire                  delay_done;
   wire [2:0]            ch_wr;
   wire [2:0]            ch_ol;
   wire [2:0]            ch_oc;
   wire [2:0]            ch_sum;
   wire [2:0]            ch_live;
   wire [4:0]            misc_cond;
   wire [4:0]            misc_clr;
   wire                  wr_sensor;
   wire                  wr_supply;
   wire                  sup_live;
   // register images, unused positions tied low
   wire [23:0]           img_ch;
   wire [7:0]            img_sensor;
   wire [7:0]            img_supply;

   // ----------------------------------------------------------------------
   // pull-down enables
   // ----------------------------------------------------------------------
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         pd_en_r <= `FSO_PD_EN_RST;
      end else begin
         pd_en_r <= ~pulldown_off_i & {3{~sleep_i}};
      end
   end

   assign pulldown_en_o = pd_en_r;

   // ----------------------------------------------------------------------
   // fault delay timer
   // ----------------------------------------------------------------------
   assign cs_rise    = ~cs_n_q_r & chip_select_n_i;
   assign delay_done = (dly_cnt_r == {`FSO_CNT_W{1'b0}});

   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         cs_n_q_r  <= 1'b1;
         dly_cnt_r <= FILT_CYC;
      end else begin
         cs_n_q_r <= chip_select_n_i;
         if (cs_rise) begin
            dly_cnt_r <= FILT_CYC;
         end else if (!delay_done) begin
            dly_cnt_r <= dly_cnt_r - {{(`FSO_CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // ----------------------------------------------------------------------
   // predriver channels
   // ----------------------------------------------------------------------
   assign ch_wr[0] = reg_wr_i & (reg_addr_i == `FSO_ADDR_HEATER);
   assign ch_wr[1] = reg_wr_i & (reg_addr_i == `FSO_ADDR_SPARK1);
   assign ch_wr[2] = reg_wr_i & (reg_addr_i == `FSO_ADDR_SPARK2);

   genvar gi;
   generate
      for (gi = 0; gi < `FSO_NUM_CH; gi = gi + 1) begin : g_ch
         fso_ol_channel #(
            .FILT_CYC (FILT_CYC)
         ) u_ch (
            .sys_clk_i          (sys_clk_i),
            .sys_rst_i          (sys_rst_i),
            .out_on_i           (pd_out_on_i[gi]),
            .ol_cmp_i           (pd_ol_cmp_i[gi]),
            .oc_det_i           (pd_oc_det_i[gi]),
            .pd_en_i            (pd_en_r[gi]),
            .delay_done_i       (delay_done),
            .wr_i               (ch_wr[gi]),
            .wdata_i            (reg_wdata_i),
            .open_load_flag_o   (ch_ol[gi]),
            .overcurrent_flag_o (ch_oc[gi]),
            .sum_flag_o         (ch_sum[gi]),
            .fault_live_o       (ch_live[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // supply, system and k-line sticky bits
   // ----------------------------------------------------------------------
   assign wr_sensor = reg_wr_i & (reg_addr_i == `FSO_ADDR_SENSOR);
   assign wr_supply = reg_wr_i & (reg_addr_i == `FSO_ADDR_SUPPLY);

   // order: k-line ot, spi error, vprot to battery, vprot ot, vprot to ground
   assign misc_cond = {kline_ot_i, spi_error_i, vprot_bat_i, vprot_ot_i, vprot_gnd_i};
   assign misc_clr  = {wr_sensor & ~reg_wdata_i[`FSO_BIT_KLINEOT],
                       wr_supply & ~reg_wdata_i[`FSO_BIT_SPIERR],
                       wr_supply & ~reg_wdata_i[`FSO_BIT_VPBAT],
                       wr_supply & ~reg_wdata_i[`FSO_BIT_VPOT],
                       wr_supply & ~reg_wdata_i[`FSO_BIT_VPGND]};
   assign sup_live  = |misc_cond[3:0];

   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_misc
         always @(posedge sys_clk_i) begin
            if (sys_rst_i) begin
               misc_r[gi] <= 1'b0;
            end else if (misc_cond[gi]) begin
               misc_r[gi] <= 1'b1;
            end else if (misc_clr[gi]) begin
               misc_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         sup_sum_r <= 1'b0;
      end else if (sup_live || (|ch_live)) begin
         sup_sum_r <= 1'b1;
      end else if (wr_supply && !reg_wdata_i[`FSO_BIT_SUM]) begin
         sup_sum_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // register images
   // ----------------------------------------------------------------------
   // one byte per predriver channel, heater in the lowest byte
   generate
      for (gi = 0; gi < `FSO_NUM_CH; gi = gi + 1) begin : g_img
         assign img_ch[gi*8+`FSO_BIT_SUM] = ch_sum[gi];
         assign img_ch[gi*8+6]            = 1'b0;
         assign img_ch[gi*8+5]            = 1'b0;
         assign img_ch[gi*8+4]            = 1'b0;
         assign img_ch[gi*8+`FSO_BIT_OL]  = ch_ol[gi];
         assign img_ch[gi*8+`FSO_BIT_OC]  = ch_oc[gi];
         assign img_ch[gi*8+1]            = 1'b0;
         assign img_ch[gi*8+0]            = 1'b0;
      end
   endgenerate

   // pickup conditioner and k-line byte
   assign img_sensor[7:4]               = pickup_peak_i;
   assign img_sensor[3]                 = 1'b0;
   assign img_sensor[`FSO_BIT_POSCLAMP] = pickup_pos_clamp_i;
   assign img_sensor[`FSO_BIT_NEGCLAMP] = pickup_neg_clamp_i;
   assign img_sensor[`FSO_BIT_KLINEOT]  = misc_r[4];

   // supply and system byte
   assign img_supply[`FSO_BIT_SUM]     = sup_sum_r;
   assign img_supply[`FSO_BIT_KEYSW]   = keysw_i;
   assign img_supply[`FSO_BIT_PWRHOLD] = power_hold_output_i;
   assign img_supply[`FSO_BIT_BATSW]   = batsw_i;
   assign img_supply[`FSO_BIT_SPIERR]  = misc_r[3];
   assign img_supply[`FSO_BIT_VPBAT]   = misc_r[2];
   assign img_supply[`FSO_BIT_VPOT]    = misc_r[1];
   assign img_supply[`FSO_BIT_VPGND]   = misc_r[0];

   // ----------------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------------
   always @* begin
      rdata_nxt = `FSO_DATA_RST;
      case (reg_addr_i)
         `FSO_ADDR_HEATER: begin
            rdata_nxt = img_ch[7:0];
         end
         `FSO_ADDR_SPARK1: begin
            rdata_nxt = img_ch[15:8];
         end
         `FSO_ADDR_SPARK2: begin
            rdata_nxt = img_ch[23:16];
         end
         `FSO_ADDR_WDOG: begin
            rdata_nxt = wd_state_i;
         end
         `FSO_ADDR_SENSOR: begin
            rdata_nxt = img_sensor;
         end
         `FSO_ADDR_SUPPLY: begin
            rdata_nxt = img_supply;
         end
         `FSO_ADDR_ONIND: begin
            rdata_nxt = out_on_ind_i;
         end
         `FSO_ADDR_MODEL: begin
            rdata_nxt = `FSO_MODEL_REV;
         end
         default: begin
            rdata_nxt = `FSO_DATA_RST;
         end
      endcase
   end

   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rdata_r  <= `FSO_DATA_RST;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= reg_rd_i;
         if (reg_rd_i) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   assign reg_rdata_o  = rdata_r;
   assign reg_rvalid_o = rvalid_r;

endmodule // fso_status_bank

`default_nettype wire

// [src/fso_map.vh]
`ifndef FSO_MAP_VH
`define FSO_MAP_VH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define FSO_ADDR_HEATER    4'h7
`define FSO_ADDR_SPARK1    4'h8
`define FSO_ADDR_SPARK2    4'h9
`define FSO_ADDR_WDOG      4'ha
`define FSO_ADDR_SENSOR    4'hb
`define FSO_ADDR_SUPPLY    4'hd
`define FSO_ADDR_ONIND     4'he
`define FSO_ADDR_MODEL     4'hf

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FSO_BIT_SUM        7
`define FSO_BIT_OL         3
`define FSO_BIT_OC         2
`define FSO_BIT_KEYSW      6
`define FSO_BIT_PWRHOLD    5
`define FSO_BIT_BATSW      4
`define FSO_BIT_SPIERR     3
`define FSO_BIT_VPBAT      2
`define FSO_BIT_VPOT       1
`define FSO_BIT_VPGND      0
`define FSO_BIT_POSCLAMP   2
`define FSO_BIT_NEGCLAMP   1
`define FSO_BIT_KLINEOT    0

// ----------------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------------
`define FSO_NUM_CH         3
`define FSO_PD_EN_RST      3'h7
`define FSO_DATA_RST       8'h00
// model and revision value is arbitrary
`define FSO_MODEL_REV      8'h5a

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FSO_CLK_MHZ        100
`define FSO_FILT_MIN_US    100
`define FSO_FILT_MAX_US    450
// minimum filter span in clocks: 100 us at 100 MHz
`define FSO_FILT_CYC       16'd10000
`define FSO_CNT_W          16

`endif

// [src/fso_ol_channel.v]
`include "fso_map.vh"
`default_nettype none

module fso_ol_channel #(
   parameter [`FSO_CNT_W-1:0] FILT_CYC = `FSO_FILT_CYC
) (
   // clock and reset
   input  wire       sys_clk_i,
   input  wire       sys_rst_i,
   // output state and analog results
   input  wire       out_on_i,
   input  wire       ol_cmp_i,
   input  wire       oc_det_i,
   input  wire       pd_en_i,
   input  wire       delay_done_i,
   // register write
   input  wire       wr_i,
   input  wire [7:0] wdata_i,
   // flags
   output wire       open_load_flag_o,
   output wire       overcurrent_flag_o,
   output wire       sum_flag_o,
   output wire       fault_live_o
);

   reg  [`FSO_CNT_W-1:0] filt_cnt_r;
   reg                   ol_r;
   reg                   oc_r;
   reg                   sum_r;
   wire                  ol_cond;
   wire                  ol_hit;

   // ----------------------------------------------------------------------
   // open load qualification and filter
   // ----------------------------------------------------------------------
   assign ol_cond = ~out_on_i & pd_en_i & delay_done_i & ol_cmp_i;
   assign ol_hit  = (filt_cnt_r == FILT_CYC);

   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         filt_cnt_r <= {`FSO_CNT_W{1'b0}};
      end else if (!ol_cond) begin
         filt_cnt_r <= {`FSO_CNT_W{1'b0}};
      end else if (!ol_hit) begin
         filt_cnt_r <= filt_cnt_r + {{(`FSO_CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // ----------------------------------------------------------------------
   // sticky flags, set wins over clear
   // ----------------------------------------------------------------------
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ol_r  <= 1'b0;
         oc_r  <= 1'b0;
         sum_r <= 1'b0;
      end else begin
         if (ol_hit) begin
            ol_r <= 1'b1;
         end else if (wr_i && !wdata_i[`FSO_BIT_OL] && !ol_cond) begin
            ol_r <= 1'b0;
         end
         if (oc_det_i) begin
            oc_r <= 1'b1;
         end else if (wr_i && !wdata_i[`FSO_BIT_OC]) begin
            oc_r <= 1'b0;
         end
         if (ol_hit || oc_det_i) begin
            sum_r <= 1'b1;
         end else if (wr_i && !wdata_i[`FSO_BIT_SUM] && !ol_cond) begin
            sum_r <= 1'b0;
         end
      end
   end

   assign open_load_flag_o   = ol_r & pd_en_i;
   assign overcurrent_flag_o = oc_r;
   assign sum_flag_o         = sum_r;
   assign fault_live_o       = ol_cond | oc_det_i;

endmodule // fso_ol_channel

`default_nettype wire

// [tb/fso_status_bank_assertions.sv]
`default_nettype none
module fso_status_bank_assertions (
   // clock and reset
   input wire logic       sys_clk_i,
   input wire logic       sys_rst_i,
   // register port
   input wire logic [3:0] reg_addr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       reg_rvalid_o,
   // channels and pull-downs
   input wire logic [2:0] pd_oc_det_i,
   input wire logic       sleep_i,
   input wire logic [2:0] pulldown_off_i,
   input wire logic [2:0] pulldown_en_o,
   input wire logic [7:0] wd_state_i
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence oc_held;
      pd_oc_det_i[1] ##1 (pd_oc_det_i[1] && reg_rd_i && reg_addr_i == 4'h8);
   endsequence
   rvalid_pulse_a: assert property (reg_rd_i |=> reg_rvalid_o ##1 (reg_rvalid_o == $past(reg_rd_i)))
      else $error("read answer not a one cycle pulse");
   rvalid_idle_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
      else $error("read answer without request");
   model_read_a: assert property (reg_rd_i && reg_addr_i == 4'hf |=> reg_rdata_o == 8'h5a)
      else $error("model register wrong");
   unmapped_zero_a: assert property (reg_rd_i && (reg_addr_i < 4'h7 || reg_addr_i == 4'hc)
      |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
   wdog_read_a: assert property (reg_rd_i && reg_addr_i == 4'ha
      |=> reg_rdata_o == $past(wd_state_i)) else $error("watchdog state mismatch");
   pd_sleep_a: assert property (sleep_i |=> pulldown_en_o == 3'h0)
      else $error("pull-downs stay on in sleep");
   pd_follow_a: assert property (!sleep_i |=> pulldown_en_o == ~$past(pulldown_off_i))
      else $error("pull-down enable wrong");
   ol_gated_a: assert property (reg_rd_i && reg_addr_i == 4'h7 && !pulldown_en_o[0]
      |=> !reg_rdata_o[3]) else $error("open load shown with pull-down off");
   oc_summary_a: assert property (oc_held |=> reg_rdata_o[7] && reg_rdata_o[2])
      else $error("overcurrent or summary not set");
   unused_bits_a: assert property (reg_rd_i && reg_addr_i inside {4'h7, 4'h8, 4'h9}
      |=> reg_rdata_o[6:4] == 3'h0 && reg_rdata_o[1:0] == 2'h0)
      else $error("unused fault bits not zero");
endmodule // fso_status_bank_assertions
bind fso_status_bank fso_status_bank_assertions u_chk (.sys_clk_i(sys_clk_i),
   .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .pd_oc_det_i(pd_oc_det_i),
   .sleep_i(sleep_i), .pulldown_off_i(pulldown_off_i), .pulldown_en_o(pulldown_en_o),
   .wd_state_i(wd_state_i));
`default_nettype wire

// [tb/fso_host_model.sv]
`default_nettype none
module fso_host_model (
   // clock
   input wire logic        sys_clk_i,
   // register port
   output logic [3:0]      addr_o,
   output logic            wr_o,
   output logic            rd_o,
   output logic [7:0]      wdata_o,
   input wire logic [7:0]  rdata_i,
   input wire logic        rvalid_i,
   // frame select
   output logic            chip_select_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      addr_o = 4'h0;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 8'h00;
      chip_select_n_o = 1'b1;
   end
   // clears are written as zero; ones are never needed to clear anything
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk_i); #1;
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(posedge sys_clk_i); #1;
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk_i); #1;
      addr_o = a;
      rd_o = 1'b1;
      @(posedge sys_clk_i); #1;
      rd_o = 1'b0;
      addr_o = ~a;
      d = rvalid_i ? rdata_i : 8'hxx;
   endtask
   // one frame: low for a cycle, the rising edge restarts the fault delay
   task automatic frame();
      @(posedge sys_clk_i); #1;
      chip_select_n_o = 1'b0;
      @(posedge sys_clk_i); #1;
      chip_select_n_o = 1'b1;
   endtask
endmodule // fso_host_model
`default_nettype wire

// [tb/fso_status_bank_bench.sv]
`default_nettype none
module fso_status_bank_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int F = 20;
   logic sys_clk_i, sys_rst_i, sleep_i, pos_c, neg_c, kl_ot, keysw, phold, batsw;
   logic spi_e, vp_bat, vp_ot, vp_gnd;
   logic [2:0] out_on, ol_cmp, oc_det, pd_off;
   logic [7:0] wd_st, on_ind;
   logic [3:0] peak;
   wire  [3:0] addr;
   wire        wr, rd, rvalid, cs_n;
   wire  [7:0] wdata, rdata;
   wire  [2:0] pd_en;
   int         n_mismatch = 0;
   int         num_checks = 0;
   fso_status_bank #(.FILT_CYC(16'd20)) u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .chip_select_n_i(cs_n),
      .pd_out_on_i(out_on), .pd_ol_cmp_i(ol_cmp), .pd_oc_det_i(oc_det), .sleep_i(sleep_i),
      .pulldown_off_i(pd_off), .pulldown_en_o(pd_en), .wd_state_i(wd_st),
      .pickup_peak_i(peak), .pickup_pos_clamp_i(pos_c), .pickup_neg_clamp_i(neg_c),
      .kline_ot_i(kl_ot), .keysw_i(keysw), .power_hold_output_i(phold), .batsw_i(batsw),
      .spi_error_i(spi_e), .vprot_bat_i(vp_bat), .vprot_ot_i(vp_ot), .vprot_gnd_i(vp_gnd),
      .out_on_ind_i(on_ind));
   fso_host_model u_host (.sys_clk_i(sys_clk_i), .addr_o(addr), .wr_o(wr), .rd_o(rd),
      .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid), .chip_select_n_o(cs_n));
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_host.rd(a, d);
      chk8(d, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic conclude();
      if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #200us;
      n_mismatch++;
      conclude();
   end
   initial begin
      {sleep_i, pos_c, neg_c, kl_ot, keysw, phold, batsw, spi_e, vp_bat, vp_ot, vp_gnd} = '0;
      {out_on, ol_cmp, oc_det, pd_off, wd_st, on_ind, peak} = '0;
      sys_rst_i = 1'b1;
      tick(12);
      sys_rst_i = 1'b0;
      tick(1);
      chk8({5'h0, pd_en}, 8'h07);
      rdc(4'hf, 8'h5a);
      u_host.wr(4'hf, 8'h00);
      rdc(4'hf, 8'h5a);
      rdc(4'hc, 8'h00);
      wd_st = 8'h3c;
      on_ind = 8'hc3;
      peak = 4'h9;
      {pos_c, neg_c, keysw, phold, batsw} = 5'h1f;
      rdc(4'ha, 8'h3c);
      rdc(4'he, 8'hc3);
      rdc(4'hb, 8'h96);
      rdc(4'hd, 8'h70);
      {peak, pos_c, neg_c, keysw, phold, batsw} = '0;
      oc_det = 3'b010;
      tick(2);
      rdc(4'h8, 8'h84);
      u_host.wr(4'h8, 8'h00);
      rdc(4'h8, 8'h84);
      oc_det = 3'b000;
      rdc(4'hd, 8'h80);
      u_host.wr(4'h8, 8'h00);
      rdc(4'h8, 8'h00);
      out_on = 3'b100;
      ol_cmp = 3'b101;
      u_host.frame();
      tick(F - 4);
      rdc(4'h7, 8'h00);
      tick(2 * F + 4);
      rdc(4'h7, 8'h88);
      rdc(4'h9, 8'h00);
      rdc(4'h8, 8'h00);
      pd_off = 3'b001;
      tick(2);
      chk8({5'h0, pd_en}, 8'h06);
      rdc(4'h7, 8'h80);
      pd_off = 3'b000;
      tick(2);
      rdc(4'h7, 8'h88);
      ol_cmp = 3'b000;
      tick(2);
      rdc(4'h7, 8'h88);
      u_host.wr(4'h7, 8'h00);
      rdc(4'h7, 8'h00);
      u_host.wr(4'hd, 8'h00);
      sleep_i = 1'b1;
      tick(2);
      chk8({5'h0, pd_en}, 8'h00);
      sleep_i = 1'b0;
      {spi_e, vp_bat, vp_ot, vp_gnd, kl_ot} = 5'h1f;
      tick(2);
      {spi_e, vp_bat, vp_ot, vp_gnd, kl_ot} = '0;
      tick(1);
      rdc(4'hd, 8'h8f);
      u_host.wr(4'hd, 8'hff);
      rdc(4'hd, 8'h8f);
      u_host.wr(4'hd, 8'h00);
      rdc(4'hd, 8'h00);
      rdc(4'hb, 8'h01);
      u_host.wr(4'hb, 8'h00);
      rdc(4'hb, 8'h00);
      sys_rst_i = 1'b1;
      tick(2);
      sys_rst_i = 1'b0;
      tick(1);
      chk8({5'h0, pd_en}, 8'h07);
      rdc(4'hf, 8'h5a);
      conclude();
   end
endmodule // fso_status_bank_bench
`default_nettype wire
